// file: logic/liu_cfg_regs.sv
// Global and transmit configuration bank with host port and transmit intake
`timescale 1ns/1ps
`default_nettype none
module liu_cfg_regs #(
  parameter int NCH = liu_pkg::LIU_NCH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Host control port
  input wire logic [liu_pkg::LIU_AW-1:0] host_addr,
  input wire logic [liu_pkg::LIU_DW-1:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [liu_pkg::LIU_DW-1:0] host_rdata,
  output logic host_rdata_valid,
  // Interrupt sources and pin
  input wire logic [NCH-1:0] chan_irq_pending,
  output logic irq_pin_out,
  output logic irq_pin_oe_n,
  // Global settings
  output logic line_standard_select,
  output logic mon_rx_en,
  output logic mon_tx_en,
  output logic [1:0] mon_channel,
  // Per-channel jitter attenuator settings
  output logic [NCH-1:0] jitter_wide_bandwidth,
  output logic [NCH-1:0] ja_in_tx,
  output logic [NCH-1:0] ja_in_rx,
  output logic [NCH-1:0][7:0] ja_depth_bits,
  output logic [NCH-1:0][9:0] ja_corner_chz,
  // Per-channel transmit settings
  output logic [NCH-1:0] tx_power_down,
  output logic [NCH-1:0] tx_driver_hiz,
  output logic [NCH-1:0] enc_hdb3,
  output logic [NCH-1:0] enc_b8zs,
  output logic [NCH-1:0] enc_ami,
  output logic [NCH-1:0] enc_bypass,
  // Transmit data intake
  input wire logic [NCH-1:0] tx_line_clock,
  input wire logic [NCH-1:0] tx_single_rail_in,
  input wire logic [NCH-1:0][1:0] tx_dual_rail_in,
  output logic [NCH-1:0] tx_pos,
  output logic [NCH-1:0] tx_neg,
  output logic [NCH-1:0] tx_data_strobe
);
  import liu_pkg::*;

  // Register storage
  logic [4:0] gcfg;
  logic [3:0] mon_code;
  logic [NCH-1:0] channel_interrupt_indication_flags;
  logic soft_clr;
  logic [NCH-1:0][5:0] jitter_reg;
  logic [NCH-1:0][4:0] txcfg_reg;
  logic [NCH-1:0] line_clock_prev;

  // Address decode
  wire logic [1:0] sel_ch = host_addr[LIU_CH_HI:LIU_CH_LO];
  wire logic [5:0] sel_off = host_addr[LIU_CH_LO-1:0];
  wire logic hit_jitter = (sel_off == LIU_OFF_JITTER);
  wire logic hit_txcfg = (sel_off == LIU_OFF_TXCFG);
  wire logic hit_gcfg = (host_addr == LIU_ADDR_GCFG);
  wire logic hit_mon = (host_addr == LIU_ADDR_MON);
  wire logic hit_channel_interrupt_indication = (host_addr == LIU_ADDR_CHANNEL_INTERRUPT_INDICATION);
  wire logic hit_reset = (host_addr == LIU_ADDR_RESET);
  wire logic copy_all = gcfg[LIU_G_COPY];
  wire logic global_mask = gcfg[LIU_G_MASK];
  wire logic [1:0] pin_mode = gcfg[LIU_G_PIN_HI:LIU_G_PIN_LO];

  // Write strobes per channel, widened by broadcast
  logic [NCH-1:0] ch_sel;
  logic [NCH-1:0] wr_jitter;
  logic [NCH-1:0] wr_txcfg;
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi = gi + 1)
    begin : g_wr
      assign ch_sel[gi] = copy_all | (sel_ch == 2'(gi));
      assign wr_jitter[gi] = host_wr & hit_jitter & ch_sel[gi];
      assign wr_txcfg[gi] = host_wr & hit_txcfg & ch_sel[gi];
    end
  endgenerate

  // Read path; reserved bits and unmapped addresses read zero
  logic [7:0] jitter_rd;
  logic [7:0] txcfg_rd;
  logic [7:0] channel_interrupt_indication_rd;
  logic [7:0] read_mux;
  assign jitter_rd = {2'h0, jitter_reg[sel_ch]};
  assign txcfg_rd = {3'h0, txcfg_reg[sel_ch]};
  generate
    for (gi = 0; gi < NCH; gi = gi + 1)
    begin : g_channel_interrupt_indication
      assign channel_interrupt_indication_rd[2*gi] = channel_interrupt_indication_flags[gi];
      assign channel_interrupt_indication_rd[2*gi+1] = 1'b0;
    end
  endgenerate
  assign read_mux = hit_gcfg ? {3'h0, gcfg} :
    hit_mon ? {mon_code, 4'h0} :
    hit_channel_interrupt_indication ? channel_interrupt_indication_rd :
    hit_jitter ? jitter_rd :
    hit_txcfg ? txcfg_rd : 8'h00;

  // Global registers; a write to the reset address is not stored
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gcfg <= LIU_GCFG_RESET;
      mon_code <= LIU_MON_RESET;
      soft_clr <= 1'b0;
    end
    else if (soft_clr)
    begin
      gcfg <= LIU_GCFG_RESET;
      mon_code <= LIU_MON_RESET;
      soft_clr <= 1'b0;
    end
    else
    begin
      soft_clr <= host_wr & hit_reset;
      if (host_wr & hit_gcfg)
        gcfg <= host_wdata[4:0];
      if (host_wr & hit_mon)
        mon_code <= host_wdata[LIU_MON_HI:LIU_MON_LO];
    end
  end

  // Host read answer, one cycle after the strobe
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_rdata <= 8'h00;
      host_rdata_valid <= 1'b0;
    end
    else
    begin
      host_rdata_valid <= host_rd & ~host_wr;
      if (host_rd & ~host_wr)
        host_rdata <= read_mux;
    end
  end

  // Channel indication follows the pending inputs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      channel_interrupt_indication_flags <= '0;
    else if (soft_clr)
      channel_interrupt_indication_flags <= '0;
    else
      channel_interrupt_indication_flags <= chan_irq_pending;
  end

  // Interrupt pin
  wire logic irq_active = (|channel_interrupt_indication_flags) & ~global_mask;
  wire logic open_drain = ~pin_mode[LIU_G_PIN_LO];
  wire logic active_high = pin_mode[LIU_G_PIN_HI];
  wire logic next_irq_pin_out = open_drain ? 1'b0 :
    (active_high ? irq_active : ~irq_active);
  wire logic next_irq_pin_oe_n = open_drain ? ~irq_active : 1'b0;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_pin_out <= 1'b0;
      irq_pin_oe_n <= 1'b1;
    end
    else
    begin
      irq_pin_out <= next_irq_pin_out;
      irq_pin_oe_n <= next_irq_pin_oe_n;
    end
  end

  // Global decode and monitor selection; odd codes select nothing
  wire logic mon_valid = ~mon_code[0] & (mon_code[2:1] != 2'h0);
  wire logic next_mon_rx_en = mon_valid & ~mon_code[3];
  wire logic next_mon_tx_en = mon_valid & mon_code[3];
  wire logic [1:0] next_mon_channel = mon_valid ? mon_code[2:1] : 2'h0;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_standard_select <= 1'b0;
      mon_rx_en <= 1'b0;
      mon_tx_en <= 1'b0;
      mon_channel <= 2'h0;
    end
    else
    begin
      line_standard_select <= gcfg[LIU_G_LINE_STD];
      mon_rx_en <= next_mon_rx_en;
      mon_tx_en <= next_mon_tx_en;
      mon_channel <= next_mon_channel;
    end
  end

  // Per-channel banks and transmit intake
  generate
    for (gi = 0; gi < NCH; gi = gi + 1)
    begin : g_ch
      liu_chan_cfg u_cfg (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .soft_clr(soft_clr),
        .wr_jitter(wr_jitter[gi]),
        .wr_txcfg(wr_txcfg[gi]),
        .wdata(host_wdata),
        .line_standard_select(line_standard_select),
        .jitter_reg(jitter_reg[gi]),
        .txcfg_reg(txcfg_reg[gi]),
        .jitter_wide_bandwidth(jitter_wide_bandwidth[gi]),
        .ja_in_tx(ja_in_tx[gi]),
        .ja_in_rx(ja_in_rx[gi]),
        .ja_depth_bits(ja_depth_bits[gi]),
        .ja_corner_chz(ja_corner_chz[gi]),
        .tx_power_down(tx_power_down[gi]),
        .enc_hdb3(enc_hdb3[gi]),
        .enc_b8zs(enc_b8zs[gi]),
        .enc_ami(enc_ami[gi]),
        .enc_bypass(enc_bypass[gi])
      );
      // Separate flop for the driver so the pin follows independently
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
          tx_driver_hiz[gi] <= 1'b0;
        else
          tx_driver_hiz[gi] <= txcfg_reg[gi][LIU_T_PDN];
      end
      // Line clock is sampled as data, so it must be well below clk_sys
      wire logic pol = txcfg_reg[gi][LIU_T_POL];
      wire logic rise_edge = txcfg_reg[gi][LIU_T_EDGE];
      wire logic dual = txcfg_reg[gi][LIU_T_MODE_HI];
      wire logic pdn = txcfg_reg[gi][LIU_T_PDN];
      wire logic rise = tx_line_clock[gi] & ~line_clock_prev[gi];
      wire logic fall = ~tx_line_clock[gi] & line_clock_prev[gi];
      wire logic take = (rise_edge ? rise : fall) & ~pdn;
      wire logic next_pos = dual ? (tx_dual_rail_in[gi][1] ^ pol) :
        (tx_single_rail_in[gi] ^ pol);
      wire logic next_neg = dual & (tx_dual_rail_in[gi][0] ^ pol);
      always_ff @(posedge clk_sys or negedge rst_n)
      begin
        if (!rst_n)
        begin
          line_clock_prev[gi] <= 1'b0;
          tx_pos[gi] <= 1'b0;
          tx_neg[gi] <= 1'b0;
          tx_data_strobe[gi] <= 1'b0;
        end
        else
        begin
          line_clock_prev[gi] <= tx_line_clock[gi];
          tx_data_strobe[gi] <= take;
          if (pdn)
          begin
            tx_pos[gi] <= 1'b0;
            tx_neg[gi] <= 1'b0;
          end
          else if (take)
          begin
            tx_pos[gi] <= next_pos;
            tx_neg[gi] <= next_neg;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// file: logic/liu_chan_cfg.sv
// Per-channel jitter and transmit configuration registers with decode
`timescale 1ns/1ps
`default_nettype none
module liu_chan_cfg (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic soft_clr,
  // Register writes
  input wire logic wr_jitter,
  input wire logic wr_txcfg,
  input wire logic [liu_pkg::LIU_DW-1:0] wdata,
  input wire logic line_standard_select,
  // Raw register contents
  output logic [5:0] jitter_reg,
  output logic [4:0] txcfg_reg,
  // Decoded settings
  output logic jitter_wide_bandwidth,
  output logic ja_in_tx,
  output logic ja_in_rx,
  output logic [7:0] ja_depth_bits,
  output logic [9:0] ja_corner_chz,
  output logic tx_power_down,
  output logic enc_hdb3,
  output logic enc_b8zs,
  output logic enc_ami,
  output logic enc_bypass
);
  import liu_pkg::*;
  wire logic [1:0] path = jitter_reg[LIU_J_PATH_HI:LIU_J_PATH_LO];
  wire logic [1:0] depth = jitter_reg[LIU_J_DEPTH_HI:LIU_J_DEPTH_LO];
  wire logic [1:0] mode = txcfg_reg[LIU_T_MODE_HI:LIU_T_MODE_LO];
  wire logic corner = jitter_reg[LIU_J_CORNER];
  wire logic zsub = (mode == LIU_TXM_ZSUB);
  wire logic [7:0] next_depth = (depth == LIU_DEPTH_128) ? LIU_BITS_128 :
    (depth == LIU_DEPTH_64) ? LIU_BITS_64 : LIU_BITS_32;
  wire logic [9:0] next_corner = line_standard_select ?
    (corner ? LIU_CHZ_T1_NARROW : LIU_CHZ_T1_NORMAL) :
    (corner ? LIU_CHZ_E1_NARROW : LIU_CHZ_E1_NORMAL);
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      jitter_reg <= LIU_JITTER_RESET;
      txcfg_reg <= LIU_TXCFG_RESET;
    end
    else if (soft_clr)
    begin
      jitter_reg <= LIU_JITTER_RESET;
      txcfg_reg <= LIU_TXCFG_RESET;
    end
    else
    begin
      if (wr_jitter)
        jitter_reg <= wdata[5:0];
      if (wr_txcfg)
        txcfg_reg <= wdata[4:0];
    end
  end
  // Decoded outputs are registered so the top drives them from flops
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      jitter_wide_bandwidth <= 1'b0;
      ja_in_tx <= 1'b0;
      ja_in_rx <= 1'b0;
      ja_depth_bits <= LIU_BITS_128;
      ja_corner_chz <= LIU_CHZ_E1_NORMAL;
      tx_power_down <= 1'b0;
      enc_hdb3 <= 1'b1;
      enc_b8zs <= 1'b0;
      enc_ami <= 1'b0;
      enc_bypass <= 1'b0;
    end
    else
    begin
      jitter_wide_bandwidth <= jitter_reg[LIU_J_WIDE];
      ja_in_tx <= (path == LIU_PATH_TX);
      ja_in_rx <= (path == LIU_PATH_RX);
      ja_depth_bits <= next_depth;
      ja_corner_chz <= next_corner;
      tx_power_down <= txcfg_reg[LIU_T_PDN];
      enc_hdb3 <= zsub & ~line_standard_select;
      enc_b8zs <= zsub & line_standard_select;
      enc_ami <= (mode == LIU_TXM_AMI);
      enc_bypass <= mode[1];
    end
  end
endmodule
`default_nettype wire

// file: pkg/liu_pkg.sv
// Constants for the line interface global and transmit configuration bank
// Operation
// - Line standard bit: clear E1, set T1/J1
// - Broadcast bit copies channel writes everywhere
// - Global mask set blocks every channel interrupt
// - Pin mode: x0 open-drain, 01/11 push-pull
// - Monitor codes 0010-0110 pick receivers, 0000 and odd reserved
// - Monitor codes 1010-1110 pick transmitters, 1000 selects nothing
// - Indication bits 0,2,4,6 flag channels 1-4
// - Wide bandwidth bit selects jitter limit mode
// - Path field: bypass, transmit or receive
// - Depth field: 128, 64 or 32 bits
// - Corner bit picks transfer corner per standard
// - Power down bit idles transmitter, driver high-Z
// - Polarity bit makes transmit inputs active low
// - Edge bit: clear falling, set rising sample
// - Mode field: zero-sub, AMI or dual-rail bypass
// - Any reset-register write restores all defaults
package liu_pkg;
  localparam int LIU_AW = 8;
  localparam int LIU_DW = 8;
  localparam int LIU_NCH = 4;
  // Address map
  localparam logic [7:0] LIU_ADDR_RESET = 8'h20;
  localparam logic [7:0] LIU_ADDR_GCFG = 8'h40;
  localparam logic [7:0] LIU_ADDR_MON = 8'h60;
  localparam logic [7:0] LIU_ADDR_CHANNEL_INTERRUPT_INDICATION = 8'h80;
  localparam logic [5:0] LIU_OFF_JITTER = 6'h01;
  localparam logic [5:0] LIU_OFF_TXCFG = 6'h02;
  localparam int LIU_CH_HI = 7;
  localparam int LIU_CH_LO = 6;
  // Global configuration fields
  localparam int LIU_G_LINE_STD = 4;
  localparam int LIU_G_COPY = 3;
  localparam int LIU_G_MASK = 2;
  localparam int LIU_G_PIN_HI = 1;
  localparam int LIU_G_PIN_LO = 0;
  localparam logic [4:0] LIU_GCFG_RESET = 5'h04;
  localparam int LIU_MON_HI = 7;
  localparam int LIU_MON_LO = 4;
  localparam logic [3:0] LIU_MON_RESET = 4'h0;
  // Jitter attenuator fields
  localparam int LIU_J_WIDE = 5;
  localparam int LIU_J_PATH_HI = 4;
  localparam int LIU_J_PATH_LO = 3;
  localparam int LIU_J_DEPTH_HI = 2;
  localparam int LIU_J_DEPTH_LO = 1;
  localparam int LIU_J_CORNER = 0;
  localparam logic [5:0] LIU_JITTER_RESET = 6'h00;
  localparam logic [1:0] LIU_PATH_TX = 2'h1;
  localparam logic [1:0] LIU_PATH_RX = 2'h3;
  localparam logic [1:0] LIU_DEPTH_128 = 2'h0;
  localparam logic [1:0] LIU_DEPTH_64 = 2'h1;
  localparam logic [7:0] LIU_BITS_128 = 8'h80;
  localparam logic [7:0] LIU_BITS_64 = 8'h40;
  localparam logic [7:0] LIU_BITS_32 = 8'h20;
  // Corners in hundredths of a hertz
  localparam logic [9:0] LIU_CHZ_T1_NORMAL = 10'h1F4;
  localparam logic [9:0] LIU_CHZ_E1_NORMAL = 10'h2A8;
  localparam logic [9:0] LIU_CHZ_T1_NARROW = 10'h07D;
  localparam logic [9:0] LIU_CHZ_E1_NARROW = 10'h05A;
  // Transmit configuration fields
  localparam int LIU_T_PDN = 4;
  localparam int LIU_T_POL = 3;
  localparam int LIU_T_EDGE = 2;
  localparam int LIU_T_MODE_HI = 1;
  localparam int LIU_T_MODE_LO = 0;
  localparam logic [4:0] LIU_TXCFG_RESET = 5'h00;
  localparam logic [1:0] LIU_TXM_ZSUB = 2'h0;
  localparam logic [1:0] LIU_TXM_AMI = 2'h1;
endpackage

// file: test/liu_cfg_regs_monitor.sv
// Port checker for the configuration bank
`timescale 1ns/1ps
`default_nettype none
module liu_cfg_regs_monitor #(
  parameter int NCH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Host port
  input wire logic [liu_pkg::LIU_AW-1:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [liu_pkg::LIU_DW-1:0] host_rdata,
  input wire logic host_rdata_valid,
  // Interrupt and global outputs
  input wire logic [NCH-1:0] chan_irq_pending,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe_n,
  input wire logic line_standard_select,
  input wire logic mon_rx_en,
  input wire logic mon_tx_en,
  input wire logic [1:0] mon_channel,
  // Transmit side
  input wire logic [NCH-1:0] tx_power_down,
  input wire logic [NCH-1:0] tx_driver_hiz,
  input wire logic [NCH-1:0] tx_line_clock,
  input wire logic [NCH-1:0] tx_data_strobe
);
  import liu_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_RD_VALID: assert property (host_rd && !host_wr |=> host_rdata_valid)
    else $error("read not answered");
  AST_VALID_CAUSE: assert property (host_rdata_valid |->
    $past(host_rd && !host_wr))
    else $error("read valid without read");
  // Indication mirrors pending one cycle late, then the read register
  AST_CHANNEL_INTERRUPT_INDICATION_MAP: assert property (host_rd && !host_wr &&
    host_addr == LIU_ADDR_CHANNEL_INTERRUPT_INDICATION |=>
    host_rdata[0] == $past(chan_irq_pending[0], 2) &&
    host_rdata[2] == $past(chan_irq_pending[1], 2) &&
    host_rdata[4] == $past(chan_irq_pending[2], 2) &&
    host_rdata[6] == $past(chan_irq_pending[3], 2) &&
    host_rdata[7] == 1'b0)
    else $error("indication read wrong");
  AST_PIN_MODE: assert property (irq_pin_oe_n |-> !irq_pin_out)
    else $error("pin drives high while released");
  AST_PDN_HIZ: assert property (tx_power_down == tx_driver_hiz)
    else $error("driver high-Z differs from power down");
  AST_STROBE_CAUSE: assert property (tx_data_strobe[0] |->
    $past(tx_line_clock[0]) != $past(tx_line_clock[0], 2))
    else $error("capture without line clock edge");
  AST_STROBE_PULSE: assert property (tx_data_strobe[0] |=>
    !tx_data_strobe[0])
    else $error("strobe longer than one cycle");
  AST_SOFT_RST: assert property (host_wr &&
    host_addr == LIU_ADDR_RESET |->
    ##5 (!line_standard_select && !mon_rx_en && !mon_tx_en))
    else $error("soft reset left settings");
  AST_MON_SEL: assert property (
    ((mon_channel != 2'h0) == (mon_rx_en || mon_tx_en)) &&
    !(mon_rx_en && mon_tx_en))
    else $error("monitor select inconsistent");
  cover property (host_rd && host_addr == LIU_ADDR_CHANNEL_INTERRUPT_INDICATION);
  cover property (tx_data_strobe[0]);
  cover property (host_wr && host_addr == LIU_ADDR_RESET);
endmodule
bind liu_cfg_regs liu_cfg_regs_monitor #(.NCH(NCH)) mon_u (.clk_sys(clk_sys),
  .rst_n(rst_n), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
  .host_rdata(host_rdata), .host_rdata_valid(host_rdata_valid),
  .chan_irq_pending(chan_irq_pending), .irq_pin_out(irq_pin_out),
  .irq_pin_oe_n(irq_pin_oe_n), .line_standard_select(line_standard_select),
  .mon_rx_en(mon_rx_en), .mon_tx_en(mon_tx_en), .mon_channel(mon_channel),
  .tx_power_down(tx_power_down), .tx_driver_hiz(tx_driver_hiz),
  .tx_line_clock(tx_line_clock), .tx_data_strobe(tx_data_strobe));
`default_nettype wire

// file: test/liu_cfg_regs_tb_top.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module liu_cfg_regs_tb_top;
  import liu_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n, host_wr, host_rd, vld, pin_out, pin_oe_n, std, m_rx, m_tx;
  logic [7:0] host_addr, host_wdata, host_rdata, rd_v;
  logic [1:0] m_ch;
  logic [3:0] pend, wide, ja_tx, ja_rx, pdn, hiz, hdb3, b8zs, ami, byp;
  logic [3:0] lclk, srail, pos, neg, strb;
  logic strb_seen;
  logic [3:0][7:0] depth;
  logic [3:0][9:0] corner;
  logic [3:0][1:0] drail;
  logic [7:0] pin_cfg [6] = '{8'h04, 8'h00, 8'h01, 8'h03, 8'h02, 8'h07};
  logic [1:0] pin_exp [6] = '{2'b10, 2'b00, 2'b00, 2'b01, 2'b00, 2'b00};
  int err_total, tests_run, cyc;
  always #2 clk_sys = ~clk_sys;
  liu_host_model host_u (.clk_sys(clk_sys), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata(host_rdata), .host_rdata_valid(vld));
  liu_cfg_regs dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
    .host_rdata(host_rdata), .host_rdata_valid(vld), .chan_irq_pending(pend),
    .irq_pin_out(pin_out), .irq_pin_oe_n(pin_oe_n), .line_standard_select(std),
    .mon_rx_en(m_rx), .mon_tx_en(m_tx), .mon_channel(m_ch),
    .jitter_wide_bandwidth(wide), .ja_in_tx(ja_tx), .ja_in_rx(ja_rx),
    .ja_depth_bits(depth), .ja_corner_chz(corner), .tx_power_down(pdn),
    .tx_driver_hiz(hiz), .enc_hdb3(hdb3), .enc_b8zs(b8zs), .enc_ami(ami),
    .enc_bypass(byp), .tx_line_clock(lclk), .tx_single_rail_in(srail),
    .tx_dual_rail_in(drail), .tx_pos(pos), .tx_neg(neg),
    .tx_data_strobe(strb));
  task automatic final_report();
    $display("mismatches=%0d comparisons=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Whole run needs a few hundred cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      final_report();
    end
  end
  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    host_u.rd8(a, rd_v);
    `CHK(rd_v, e)
  endtask
  // Decoded outputs lag a write by up to three clocks
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    host_u.wr8(a, d);
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic tick(input logic c, input logic d, input logic [1:0] dr);
    @(negedge clk_sys);
    lclk[0] = c;
    srail[0] = d;
    drail[0] = dr;
    // Strobe stands for one cycle only, so catch it while it stands
    @(negedge clk_sys);
    strb_seen = strb[0];
    repeat (2) @(negedge clk_sys);
  endtask
  initial
  begin
    logic [1:0] k;
    logic [3:0] m, mon_exp;
    pend = 4'h0;
    lclk = 4'hF;
    srail = 4'h0;
    drail = '0;
    rst_n = 1'b0;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    chk_rd(8'h40, 8'h04);
    chk_rd(8'h60, 8'h00);
    chk_rd(8'h80, 8'h00);
    chk_rd(8'h01, 8'h00);
    chk_rd(8'h20, 8'h00);
    chk_rd(8'h05, 8'h00);
    `CHK({depth[0], corner[0], hdb3}, {8'h80, 10'h2A8, 4'hF})
    w(8'h80, 8'hFF);
    chk_rd(8'h80, 8'h00);
    w(8'h01, 8'hFF);
    chk_rd(8'h01, 8'h3F);
    for (int i = 0; i < 4; i++)
    begin
      k = i[1:0];
      w(8'h81, {2'b00, k[0], k, k, 1'b0});
      `CHK({wide[2], ja_tx[2], ja_rx[2]}, {k[0], k == 1, k == 3})
      `CHK(depth[2], (k == 2'd0) ? 8'h80 : (k == 2'd1) ? 8'h40 : 8'h20)
      w(8'h42, {6'h00, k});
      `CHK({hdb3[1], b8zs[1], ami[1], byp[1]}, {!k, 1'b0, k == 1, k[1]})
    end
    w(8'h42, 8'h00);
    w(8'h40, 8'h10);
    `CHK({std, hdb3[1], b8zs[1], corner[1]}, {3'b101, 10'h1F4})
    w(8'h41, 8'h01);
    `CHK(corner[1], 10'h07D)
    w(8'h40, 8'h00);
    `CHK({std, corner[1]}, {1'b0, 10'h05A})
    w(8'h40, 8'h08);
    w(8'hC2, 8'h10);
    `CHK({pdn, hiz}, 8'hFF)
    chk_rd(8'h02, 8'h10);
    w(8'h40, 8'h00);
    w(8'h02, 8'h00);
    `CHK(pdn, 4'hE)
    for (int i = 0; i < 16; i++)
    begin
      m = i[3:0];
      w(8'h60, {m, 4'hF});
      mon_exp = (m[0] || m[2:1] == 2'd0) ? 4'h0 : {~m[3], m[3], m[2:1]};
      `CHK({m_rx, m_tx, m_ch}, mon_exp)
      chk_rd(8'h60, {m, 4'h0});
    end
    pend = 4'b0101;
    chk_rd(8'h80, 8'h11);
    for (int i = 0; i < 6; i++)
    begin
      w(8'h40, pin_cfg[i]);
      `CHK({pin_oe_n, pin_out}, pin_exp[i])
    end
    pend = 4'h0;
    w(8'h40, 8'h01);
    `CHK({pin_oe_n, pin_out}, 2'b01)
    tick(1'b1, 1'b1, 2'b00);
    tick(1'b0, 1'b1, 2'b00);
    `CHK({pos[0], neg[0], strb_seen}, 3'b101)
    w(8'h02, 8'h08);
    tick(1'b1, 1'b1, 2'b00);
    tick(1'b0, 1'b1, 2'b00);
    `CHK({pos[0], neg[0]}, 2'b00)
    w(8'h02, 8'h04);
    tick(1'b1, 1'b1, 2'b00);
    `CHK({pos[0], neg[0]}, 2'b10)
    tick(1'b0, 1'b0, 2'b00);
    `CHK({pos[0], neg[0], strb_seen}, 3'b100)
    w(8'h02, 8'h06);
    tick(1'b1, 1'b0, 2'b01);
    `CHK({pos[0], neg[0]}, 2'b01)
    w(8'h02, 8'h0E);
    tick(1'b0, 1'b0, 2'b01);
    tick(1'b1, 1'b0, 2'b01);
    `CHK({pos[0], neg[0]}, 2'b10)
    w(8'h02, 8'h14);
    tick(1'b0, 1'b1, 2'b00);
    tick(1'b1, 1'b1, 2'b00);
    `CHK({pos[0], neg[0], strb_seen}, 3'b000)
    w(8'h40, 8'h1B);
    host_u.wr8(8'h20, 8'h5A);
    repeat (8) @(negedge clk_sys);
    chk_rd(8'h40, 8'h04);
    chk_rd(8'h02, 8'h00);
    `CHK(std, 1'b0)
    final_report();
  end
endmodule
`default_nettype wire

// file: test/liu_host_model.sv
// Host processor model for the register port
`timescale 1ns/1ps
`default_nettype none
module liu_host_model (
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic [liu_pkg::LIU_AW-1:0] host_addr,
  output logic [liu_pkg::LIU_DW-1:0] host_wdata,
  output logic host_wr,
  output logic host_rd,
  input wire logic [liu_pkg::LIU_DW-1:0] host_rdata,
  input wire logic host_rdata_valid
);
  import liu_pkg::*;
  initial
  begin
    host_addr = 8'h00;
    host_wdata = 8'h00;
    host_wr = 1'b0;
    host_rd = 1'b0;
  end
  // Idle bus shows inverted values so nothing stale looks valid
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    host_addr = a;
    host_wdata = (a == LIU_ADDR_GCFG) ? (d & 8'hDF) : d;
    host_wr = 1'b1;
    @(negedge clk_sys);
    host_wr = 1'b0;
    host_addr = ~a;
    host_wdata = ~d;
  endtask
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge clk_sys);
    host_rd = 1'b0;
    host_addr = ~a;
    d = host_rdata_valid ? host_rdata : 8'hXX;
  endtask
endmodule
`default_nettype wire
